// [rtl/qsp_sram_port.sv]
// Port logic of a separate I/O burst SRAM: write and read engines, storage,
// and the read return path towards the output clock.
// Assumes the controller drives selects, address, data and masks synchronous to
// SYS_CLK, and OUT_CLK is a free clock from the controller, unrelated in phase.
//
// What this block does
// - Write data is taken on every beat edge while a write burst runs.
// - A low write select at a start edge begins a write burst.
// - With the write port deselected the write data bus is ignored.
// - On the nine bit part two nibble selects guard bits 3:0 and 7:4.
// - An inactive nibble select leaves that stored nibble unchanged.
// - Active low byte selects guard nine bit lanes, sampled on write beats.
// - An inactive byte select keeps the stored byte and drops the incoming one.
// - Each byte select is sampled on the same edge as its data beat.
// - One shared address bus is sampled at the start edge of any access.
// - Address width is 21, 20 or 19 bits for 9, 18 or 36 data bits.
// - The address is ignored for a port that is not selected.
// - Read beats launch on the output clock, or on SYS_CLK in single clock mode.
// - A deselected read port leaves the read data bus undriven.
// - A low read select at a start edge begins a read burst.
// - A running read completes, then drivers switch off after one edge of the clock that launches beats.
// - Every read returns four beats from four sequential locations.
// - Accesses start only at a rising edge of the input clock.
`timescale 1ns/1ns
`include "qsp_consts.svh"
module qsp_sram_port
	import qsp_pkg::*;
#(
	parameter int DW     = `QSP_DW_X18,
	parameter int AW     = qsp_addr_w(DW),
	parameter int MEM_AW = AW,
	parameter int DEPTH  = `QSP_FIFO_DEPTH
) (
	input  wire logic                      SYS_CLK,
	input  wire logic                      ARST_N,
	input  wire logic                      OUT_CLK,
	input  wire logic                      SINGLE_CLK_MODE,
	input  wire logic                      WRITE_PORT_SEL_N,
	input  wire logic                      READ_PORT_SEL_N,
	input  wire logic [AW-1:0]             ADDR,
	input  wire logic [DW-1:0]             WR_DATA,
	input  wire logic [`QSP_NIB_LANES-1:0] NIBBLE_LANE_SEL_N,
	input  wire logic [DW/`QSP_LANE_W-1:0] BYTE_LANE_SEL_N,
	output wire logic [DW-1:0]             RD_DATA,
	output wire logic                      RD_DATA_OE
);
	// address width
	// AW follows the data width; MEM_AW may shrink the array to keep simulation small.
	localparam int IW = MEM_AW + `QSP_BEAT_W;

	// Storage: one word per beat, a burst is four adjacent words.
	logic [DW-1:0] mem_q [0:(1<<IW)-1];

	// Write engine state.
	qsp_eng_type          wr_st_q;
	qsp_eng_type          wr_st_d;
	logic [MEM_AW-1:0]    wr_addr_q;
	logic [`QSP_BEAT_W-1:0] wr_beat_q;

	// Read engine state and the registered beat that leaves it.
	qsp_eng_type          rd_st_q;
	qsp_eng_type          rd_st_d;
	logic [MEM_AW-1:0]    rd_addr_q;
	logic [`QSP_BEAT_W-1:0] rd_beat_q;
	logic                 out_v_q;
	logic [DW-1:0]        out_d_q;

	// Mode strap synchronisers, one pair per clock domain.
	logic                 mode_s1_q;
	logic                 mode_s2_q;
	logic                 lnk_mode_s1_q;
	logic                 lnk_mode_s2_q;

	// Output clock domain: reset release and the driven read beat.
	logic                 lnk_rst_s1_q;
	logic                 lnk_rst_n_q;
	logic [DW-1:0]        lnk_q_q;
	logic                 lnk_oe_q;

	wire                  wr_start;
	wire                  wr_en;
	wire [MEM_AW-1:0]     wr_base;
	wire [`QSP_BEAT_W-1:0] wr_beat;
	wire [IW-1:0]         wr_idx;
	wire [DW-1:0]         wr_mask;
	wire [DW-1:0]         wr_merged;
	wire                  wr_last;
	wire                  rd_start;
	wire                  rd_busy;
	wire                  rd_issue;
	wire                  rd_last;
	wire                  sink_ready;
	wire                  advance;
	wire [IW-1:0]         rd_idx;

	qsp_stream_if #(.WIDTH(DW)) ret ();

	// start on edge
	// A start is only seen while idle, so a select held low through a burst
	// does not restart it; the controller must space bursts four edges apart.
	assign wr_start = (wr_st_q == QSP_IDLE) & ~WRITE_PORT_SEL_N;

	// deselected write ignored
	// Nothing is written unless a burst starts now or is running.
	assign wr_en = wr_start | (wr_st_q == QSP_BURST);

	// unselected address ignored
	// The first beat uses the address pins directly; later beats use the copy.
	assign wr_base = wr_start ? ADDR[MEM_AW-1:0] : wr_addr_q;
	assign wr_beat = wr_start ? `QSP_FIRST_BEAT : wr_beat_q;
	assign wr_idx  = {wr_base, wr_beat};
	assign wr_last = wr_beat_q == `QSP_LAST_BEAT;

	// same edge masks
	// Masks are the pins of this very edge, so each beat carries its own mask.
	for (genvar b = 0; b < DW; b++) begin : g_mask
		if (DW == `QSP_DW_X9 && b < `QSP_NIB_LANES * `QSP_NIB_W) begin : g_nib
			assign wr_mask[b] = ~BYTE_LANE_SEL_N[b/`QSP_LANE_W] & ~NIBBLE_LANE_SEL_N[b/`QSP_NIB_W];
		end else begin : g_byte
			assign wr_mask[b] = ~BYTE_LANE_SEL_N[b/`QSP_LANE_W];
		end
	end

	// masked byte kept
	// Read-modify-write of the stored word leaves masked bits as they were.
	assign wr_merged = (mem_q[wr_idx] & ~wr_mask) | (WR_DATA & wr_mask);

	// Write engine next state.
	always_comb begin
		wr_st_d = wr_st_q;
		case (wr_st_q)
			QSP_IDLE: begin
				if (wr_start) begin
					wr_st_d = QSP_BURST;
				end
			end
			QSP_BURST: begin
				if (wr_last) begin
					wr_st_d = QSP_IDLE;
				end
			end
			default: begin
				wr_st_d = QSP_IDLE;
			end
		endcase
	end

	// write address capture
	// The beat count runs one ahead of the start beat, which is already written.
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			wr_st_q   <= QSP_IDLE;
			wr_addr_q <= '0;
			wr_beat_q <= `QSP_FIRST_BEAT;
		end else begin
			wr_st_q <= wr_st_d;
			if (wr_start) begin
				wr_addr_q <= ADDR[MEM_AW-1:0];
				wr_beat_q <= `QSP_SECOND_BEAT;
			end else if (wr_st_q == QSP_BURST) begin
				wr_beat_q <= wr_beat_q + `QSP_SECOND_BEAT;
			end
		end
	end

	// data capture beats
	// Storage has no reset; its content after power up is undefined.
	always_ff @(posedge SYS_CLK) begin
		if (wr_en) begin
			mem_q[wr_idx] <= wr_merged;
		end
	end

	// independent read engine
	// The read engine shares only the storage with the write engine, so a read
	// and a write started on one edge both run; a read of a word being written
	// on the same edge returns the old content.
	assign rd_start = (rd_st_q == QSP_IDLE) & ~READ_PORT_SEL_N;
	assign rd_busy  = rd_st_q == QSP_BURST;
	assign rd_last  = rd_beat_q == `QSP_LAST_BEAT;
	assign rd_idx   = {rd_addr_q, rd_beat_q};

	// In single clock mode beats leave straight from the output register, so
	// nothing can stall them; otherwise the return buffer pushes back.
	assign sink_ready = mode_s2_q | ret.in_ready;
	assign advance    = ~out_v_q | sink_ready;
	assign rd_issue   = rd_busy & advance;

	// Read engine next state.
	always_comb begin
		rd_st_d = rd_st_q;
		case (rd_st_q)
			QSP_IDLE: begin
				if (rd_start) begin
					rd_st_d = QSP_BURST;
				end
			end
			QSP_BURST: begin
				if (rd_issue && rd_last) begin
					rd_st_d = QSP_IDLE;
				end
			end
			default: begin
				rd_st_d = QSP_IDLE;
			end
		endcase
	end

	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rd_st_q   <= QSP_IDLE;
			rd_addr_q <= '0;
			rd_beat_q <= `QSP_FIRST_BEAT;
		end else begin
			rd_st_q <= rd_st_d;
			if (rd_start) begin
				rd_addr_q <= ADDR[MEM_AW-1:0];
				rd_beat_q <= `QSP_FIRST_BEAT;
			end else if (rd_issue) begin
				rd_beat_q <= rd_beat_q + `QSP_SECOND_BEAT;
			end
		end
	end

	// Output register of the read engine; it holds while the buffer is full.
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			out_v_q <= 1'b0;
			out_d_q <= '0;
		end else if (advance) begin
			out_v_q <= rd_issue;
			if (rd_issue) begin
				out_d_q <= mem_q[rd_idx];
			end
		end
	end

	// The mode strap is asynchronous to both clocks; it must only change while
	// no read is in flight, or a beat may be lost between the two paths.
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			mode_s1_q <= 1'b0;
			mode_s2_q <= 1'b0;
		end else begin
			mode_s1_q <= SINGLE_CLK_MODE;
			mode_s2_q <= mode_s1_q;
		end
	end

	// Filling side of the return buffer.
	assign ret.in_valid = out_v_q & ~mode_s2_q;
	assign ret.in_data  = out_d_q;

	// The output clock domain drains one beat on every edge it gets.
	assign ret.out_ready = 1'b1;

	qsp_async_fifo #(
		.WIDTH (DW),
		.DEPTH (DEPTH)
	) u_ret_fifo (
		.wr_clk    (SYS_CLK),
		.wr_arst_n (ARST_N),
		.rd_clk    (OUT_CLK),
		.rd_arst_n (lnk_rst_n_q),
		.st        (ret.fifo)
	);

	// Reset for the output clock domain: asserted at once, released on OUT_CLK.
	always_ff @(posedge OUT_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			lnk_rst_s1_q <= 1'b0;
			lnk_rst_n_q  <= 1'b0;
		end else begin
			lnk_rst_s1_q <= 1'b1;
			lnk_rst_n_q  <= lnk_rst_s1_q;
		end
	end

	// Mode level carried into the output clock domain.
	always_ff @(posedge OUT_CLK or negedge lnk_rst_n_q) begin
		if (!lnk_rst_n_q) begin
			lnk_mode_s1_q <= 1'b0;
			lnk_mode_s2_q <= 1'b0;
		end else begin
			lnk_mode_s1_q <= mode_s2_q;
			lnk_mode_s2_q <= lnk_mode_s1_q;
		end
	end

	// finish then release
	// Enable follows buffer content, so the last beat of a burst is driven for
	// one output clock period and the drivers let go at the next edge.
	always_ff @(posedge OUT_CLK or negedge lnk_rst_n_q) begin
		if (!lnk_rst_n_q) begin
			lnk_q_q  <= '0;
			lnk_oe_q <= 1'b0;
		end else begin
			lnk_oe_q <= ret.out_valid & ~lnk_mode_s2_q;
			if (ret.out_valid) begin
				lnk_q_q <= ret.out_data;
			end
		end
	end

	// idle bus undriven
	// Both sources are flip-flops; the strap only picks which one reaches the pins.
	assign RD_DATA    = mode_s2_q ? out_d_q : lnk_q_q;
	assign RD_DATA_OE = mode_s2_q ? out_v_q : lnk_oe_q;
endmodule

// [shared/qsp_consts.svh]
// Constants for the quad rate SRAM port: burst shape, lane layout, widths.
// Assumes inclusion by the package and the design modules by bare name.
`ifndef QSP_CONSTS_SVH
`define QSP_CONSTS_SVH

// Burst shape: four beats per access, counted by a two-bit beat index.
`define QSP_BURST_LEN 4
`define QSP_BEAT_W 2
`define QSP_FIRST_BEAT 2'h0
`define QSP_SECOND_BEAT 2'h1
`define QSP_LAST_BEAT 2'h3

// Lane layout: byte lanes of nine bits, nibble lanes of four bits.
`define QSP_LANE_W 9
`define QSP_NIB_W 4
`define QSP_NIB_LANES 2

// Data widths of the three variants and the address width of each.
`define QSP_DW_X9 9
`define QSP_DW_X18 18
`define QSP_DW_X36 36
`define QSP_AW_X9 21
`define QSP_AW_X18 20
`define QSP_AW_X36 19

// Depth of the read return buffer.
`define QSP_FIFO_DEPTH 16

`endif

// [shared/qsp_pkg.sv]
// Types shared by the quad rate SRAM port modules.
// Assumes the constants header is on the include path.
package qsp_pkg;
	`include "qsp_consts.svh"

	// State of the read and the write burst engines.
	typedef enum {QSP_IDLE, QSP_BURST} qsp_eng_type;

	// Address width that goes with a given data width.
	function automatic int qsp_addr_w(input int dw);
		if (dw == `QSP_DW_X9) begin
			return `QSP_AW_X9;
		end
		if (dw == `QSP_DW_X18) begin
			return `QSP_AW_X18;
		end
		return `QSP_AW_X36;
	endfunction
endpackage

// [shared/qsp_stream_if.sv]
// Valid and ready stream carrying read beats through the return buffer.
// Assumes the filling side and the draining side may sit on different clocks.
`timescale 1ns/1ns
interface qsp_stream_if #(
	parameter int WIDTH = 18
) ();
	logic             in_valid;
	logic             in_ready;
	logic [WIDTH-1:0] in_data;
	logic             out_valid;
	logic             out_ready;
	logic [WIDTH-1:0] out_data;

	// The buffer itself.
	modport fifo (
		input  in_valid,
		input  in_data,
		output in_ready,
		output out_valid,
		output out_data,
		input  out_ready
	);

	// The side that fills the buffer.
	modport producer (
		output in_valid,
		output in_data,
		input  in_ready
	);

	// The side that drains the buffer.
	modport consumer (
		input  out_valid,
		input  out_data,
		output out_ready
	);
endinterface

// [rtl/qsp_async_fifo.sv]
// Dual clock FIFO with gray coded pointers, valid and ready on both sides.
// Assumes each side has its own reset, released synchronously to its own clock.
`timescale 1ns/1ns
`include "qsp_consts.svh"
module qsp_async_fifo
	import qsp_pkg::*;
#(
	parameter int WIDTH = 18,
	parameter int DEPTH = `QSP_FIFO_DEPTH
) (
	input wire logic wr_clk,
	input wire logic wr_arst_n,
	input wire logic rd_clk,
	input wire logic rd_arst_n,
	qsp_stream_if.fifo st
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [0:DEPTH-1];
	logic [AW:0]      wbin_q;
	logic [AW:0]      wgray_q;
	logic [AW:0]      rbin_q;
	logic [AW:0]      rgray_q;
	logic [AW:0]      rgray_s1_q;
	logic [AW:0]      rgray_s2_q;
	logic [AW:0]      wgray_s1_q;
	logic [AW:0]      wgray_s2_q;
	wire              push;
	wire              pop;
	wire  [AW:0]      wbin_d;
	wire  [AW:0]      rbin_d;
	wire  [AW:0]      wgray_d;
	wire  [AW:0]      rgray_d;
	wire              full;
	wire              empty;

	// Pointer arithmetic; only gray values ever cross between the clocks.
	assign push    = st.in_valid & st.in_ready;
	assign pop     = st.out_valid & st.out_ready;
	assign wbin_d  = wbin_q + {{AW{1'b0}}, push};
	assign rbin_d  = rbin_q + {{AW{1'b0}}, pop};
	assign wgray_d = wbin_d ^ (wbin_d >> 1);
	assign rgray_d = rbin_d ^ (rbin_d >> 1);

	// Full compares against the synchronised read pointer, so it is pessimistic, never late.
	assign full         = wgray_q == {~rgray_s2_q[AW:AW-1], rgray_s2_q[AW-2:0]};
	assign empty        = rgray_q == wgray_s2_q;
	assign st.in_ready  = ~full;
	assign st.out_valid = ~empty;
	assign st.out_data  = mem_q[rbin_q[AW-1:0]];

	// Write side pointers and the read pointer synchroniser.
	always_ff @(posedge wr_clk or negedge wr_arst_n) begin
		if (!wr_arst_n) begin
			wbin_q     <= '0;
			wgray_q    <= '0;
			rgray_s1_q <= '0;
			rgray_s2_q <= '0;
		end else begin
			wbin_q     <= wbin_d;
			wgray_q    <= wgray_d;
			rgray_s1_q <= rgray_q;
			rgray_s2_q <= rgray_s1_q;
		end
	end

	// Storage is written on the filling clock only.
	always_ff @(posedge wr_clk) begin
		if (push) begin
			mem_q[wbin_q[AW-1:0]] <= st.in_data;
		end
	end

	// Read side pointers and the write pointer synchroniser.
	always_ff @(posedge rd_clk or negedge rd_arst_n) begin
		if (!rd_arst_n) begin
			rbin_q     <= '0;
			rgray_q    <= '0;
			wgray_s1_q <= '0;
			wgray_s2_q <= '0;
		end else begin
			rbin_q     <= rbin_d;
			rgray_q    <= rgray_d;
			wgray_s1_q <= wgray_q;
			wgray_s2_q <= wgray_s1_q;
		end
	end
endmodule

// [verification/qsp_ctrl_model.sv]
// Controller side model: makes the output clock and collects read beats.
// Assumes the bench reads beat_data whenever beat_ev fires.
`timescale 1ns/1ns
module qsp_ctrl_model #(
	parameter int DW = 18
) (
	input  wire logic          sys_clk,
	input  wire logic          single_mode,
	input  wire logic [DW-1:0] rd_data,
	input  wire logic          rd_oe,
	output logic               out_clk,
	output logic [DW-1:0]      beat_data
);
	event          beat_ev;
	logic [DW-1:0] last_q = '0;
	// released bus
	// A released bus must not show the old beat, so the inverse stands in.
	wire  [DW-1:0] bus_view = rd_oe ? rd_data : ~last_q;

	// controller output clock
	// The output clock runs free with a phase unrelated to the input clock.
	initial begin
		out_clk = 1'h0;
		#37;
		forever begin
			#80 out_clk = ~out_clk;
		end
	end

	// beat capture
	// Beats are taken mid-period of the launching clock, where they have settled.
	task automatic take(input logic by_sys);
		if (rd_oe === 1'h1 && by_sys == single_mode) begin
			beat_data = bus_view;
			last_q = bus_view;
			-> beat_ev;
		end
	endtask

	// Sample on whichever clock launches beats in the present mode.
	always @(negedge sys_clk) take(1'h1);
	always @(negedge out_clk) take(1'h0);
endmodule

// [verification/qsp_port_monitor.sv]
// Checker of the read port timing, seen from the top module's ports.
// Assumes the mode pin changes only while both engines are idle.
`timescale 1ns/1ns
module qsp_port_monitor #(
	parameter int DW = 18
) (
	input wire logic          SYS_CLK,
	input wire logic          ARST_N,
	input wire logic          OUT_CLK,
	input wire logic          SINGLE_CLK_MODE,
	input wire logic          WRITE_PORT_SEL_N,
	input wire logic          READ_PORT_SEL_N,
	input wire logic [DW-1:0] RD_DATA,
	input wire logic          RD_DATA_OE
);
	logic [1:0] beat_q;
	logic [2:0] idle_q;
	logic [2:0] mode_q;
	logic       mode_last_q;
	// A read starts only while no burst is counted.
	wire        rd_start  = !READ_PORT_SEL_N && beat_q == 2'h0;
	wire        single_ok = SINGLE_CLK_MODE && mode_q == 3'h7;
	wire        normal_ok = !SINGLE_CLK_MODE && mode_q == 3'h7;

	// Burst beat count, idle run and mode settling time.
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			beat_q <= 2'h0;
			idle_q <= 3'h0;
			mode_q <= 3'h0;
			mode_last_q <= 1'h0;
		end else begin
			beat_q <= rd_start ? 2'h1 : (beat_q == 2'h0 ? 2'h0 : beat_q + 2'h1);
			idle_q <= (rd_start || beat_q != 2'h0) ? 3'h0 : idle_q + {2'h0, idle_q != 3'h7};
			mode_q <= (SINGLE_CLK_MODE != mode_last_q) ? 3'h0 : mode_q + {2'h0, mode_q != 3'h7};
			mode_last_q <= SINGLE_CLK_MODE;
		end
	end

	rd_burst_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
		single_ok && rd_start |-> ##2 RD_DATA_OE [*4]) else $error("read burst not four beats");
	rd_release_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
		single_ok && rd_start ##4 READ_PORT_SEL_N [*3] |-> !RD_DATA_OE)
		else $error("drivers not released after burst");
	oe_quiet_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
		single_ok && idle_q >= 3'h3 |-> !RD_DATA_OE) else $error("bus driven while idle");
	oe_cause_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
		single_ok && $rose(RD_DATA_OE) |-> $past(rd_start, 2)) else $error("drive without read");
	wr_silent_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
		single_ok && idle_q >= 3'h3 && READ_PORT_SEL_N && !WRITE_PORT_SEL_N |=> !RD_DATA_OE [*2])
		else $error("write drove the read bus");
	reset_idle_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
		$rose(ARST_N) |-> !RD_DATA_OE && RD_DATA == '0) else $error("outputs busy after reset");
	sys_hold_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
		single_ok && $fell(RD_DATA_OE) |-> $stable(RD_DATA)) else $error("data moved at release");
	out_burst_a: assert property (@(posedge OUT_CLK) disable iff (!ARST_N)
		normal_ok && $rose(RD_DATA_OE) |-> RD_DATA_OE [*4]) else $error("output clock burst short");
	out_hold_a: assert property (@(posedge OUT_CLK) disable iff (!ARST_N)
		normal_ok && $fell(RD_DATA_OE) |-> $stable(RD_DATA)) else $error("data moved at release");

	single_read_c: cover property (@(posedge SYS_CLK) single_ok && rd_start);
	normal_read_c: cover property (@(posedge OUT_CLK) normal_ok && $rose(RD_DATA_OE));
	both_ports_c: cover property (@(posedge SYS_CLK) rd_start && !WRITE_PORT_SEL_N);
endmodule

bind qsp_sram_port qsp_port_monitor #(.DW(DW)) u_port_monitor (
	.SYS_CLK(SYS_CLK),
	.ARST_N(ARST_N),
	.OUT_CLK(OUT_CLK),
	.SINGLE_CLK_MODE(SINGLE_CLK_MODE),
	.WRITE_PORT_SEL_N(WRITE_PORT_SEL_N),
	.READ_PORT_SEL_N(READ_PORT_SEL_N),
	.RD_DATA(RD_DATA),
	.RD_DATA_OE(RD_DATA_OE)
);

// [verification/tb_top.sv]
// Self-checking bench for the SRAM port: writes, masked writes and reads.
// Assumes storage narrowed to 64 bursts; expectations come from a shadow memory.
`timescale 1ns/1ns
module tb_top;
	localparam int DW = 18;
	localparam int AW = 20;
	logic          sys_clk;
	logic          arst_n;
	logic          single_mode;
	logic          wps_n;
	logic          rps_n;
	logic [AW-1:0] addr;
	logic [DW-1:0] wr_data;
	logic [1:0]    bls_n;
	wire  [DW-1:0] rd_data;
	wire           rd_oe;
	wire           out_clk;
	wire  [DW-1:0] beat_data;
	logic [DW-1:0] ref_mem [0:255];
	logic [DW-1:0] exp_q [$];
	int            mismatches = 0;
	int            total_checks = 0;
	integer        seed = 32'h93184DC2;

	qsp_sram_port #(.DW(DW), .AW(AW), .MEM_AW(6), .DEPTH(16)) u_dut (
		.SYS_CLK(sys_clk),
		.ARST_N(arst_n),
		.OUT_CLK(out_clk),
		.SINGLE_CLK_MODE(single_mode),
		.WRITE_PORT_SEL_N(wps_n),
		.READ_PORT_SEL_N(rps_n),
		.ADDR(addr),
		.WR_DATA(wr_data),
		.NIBBLE_LANE_SEL_N(2'h3),
		.BYTE_LANE_SEL_N(bls_n),
		.RD_DATA(rd_data),
		.RD_DATA_OE(rd_oe)
	);

	qsp_ctrl_model #(.DW(DW)) u_ctrl (
		.sys_clk(sys_clk),
		.single_mode(single_mode),
		.rd_data(rd_data),
		.rd_oe(rd_oe),
		.out_clk(out_clk),
		.beat_data(beat_data)
	);

	// Input clock of 100 ns.
	initial begin
		sys_clk = 1'h0;
		forever begin
			#50 sys_clk = ~sys_clk;
		end
	end

	// Compare one read beat.
	task automatic check_word(input string what, input logic [DW-1:0] exp, input logic [DW-1:0] got);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Compare one flag.
	task automatic check_bit(input string what, input logic exp, input logic got);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %b seen %b", what, exp, got);
		end
	endtask

	// Print the counts and the verdict, then stop.
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// One four-edge slot, five with a read; kind 0 full lanes, 1 random masks, 2 masks over old data.
	// Addresses other than the start beat's are random, since they must be ignored.
	task automatic burst(input logic wr, input logic rd, input logic [5:0] a, input int kind);
		logic [DW-1:0] d;
		logic [1:0]    m;
		for (int k = 0; k < 4; k++) begin
			if (rd) exp_q.push_back(ref_mem[{a, 2'(k)}]);
		end
		for (int k = 0; k < 4; k++) begin
			d = DW'($random(seed));
			m = (kind == 0) ? 2'h0 : 2'($random(seed));
			if (kind == 2) d = ref_mem[{a, 2'(k)}] ^ {m[1] ? d[17:9] : 9'h0, m[0] ? d[8:0] : 9'h0};
			if (wr && !m[0]) ref_mem[{a, 2'(k)}][8:0] = d[8:0];
			if (wr && !m[1]) ref_mem[{a, 2'(k)}][17:9] = d[17:9];
			@(posedge sys_clk);
			wps_n <= !(wr && k == 0);
			rps_n <= !(rd && k == 0);
			addr <= (k == 0) ? {14'($random(seed)), a} : AW'($random(seed));
			wr_data <= d;
			bls_n <= m;
		end
		// The read engine is idle again only after a fifth edge, so reads need one more.
		if (rd) @(posedge sys_clk);
	endtask

	// Wait, bounded, until every noted beat has come back.
	task automatic drain(input string name);
		for (int i = 0; i < 300 && exp_q.size() != 0; i++) @(posedge sys_clk);
		repeat (4) @(posedge sys_clk);
		if (exp_q.size() != 0) begin
			mismatches++;
			$display("ERROR %s expected 0 beats left seen %0d", name, exp_q.size());
			tally_and_finish();
		end
		check_bit("rd_oe", 1'h0, rd_oe);
		$display("test %s done", name);
	endtask

	// Each beat seen by the controller model is matched to the oldest note.
	initial begin
		forever begin
			@(u_ctrl.beat_ev);
			if (exp_q.size() == 0) begin
				mismatches++;
				$display("ERROR rd_data expected no beat seen %h", beat_data);
			end else begin
				check_word("rd_data", exp_q.pop_front(), beat_data);
			end
		end
	end

	// Main sequence: fill, masked and deselected writes, reads in both modes.
	initial begin
		arst_n = 1'h0;
		single_mode = 1'h0;
		wps_n = 1'h1;
		rps_n = 1'h1;
		addr = '0;
		wr_data = '0;
		bls_n = 2'h3;
		repeat (16) @(posedge sys_clk);
		arst_n <= 1'h1;
		repeat (8) @(posedge sys_clk);
		check_bit("rd_oe", 1'h0, rd_oe);
		for (int a = 0; a < 12; a++) burst(1'h1, 1'h0, 6'(a), 0);
		for (int a = 0; a < 8; a++) burst(1'h1, 1'h0, 6'(a), 1);
		for (int a = 0; a < 4; a++) burst(1'h0, 1'h0, 6'(a), 1);
		$display("test writes done");
		for (int a = 0; a < 8; a++) burst(1'h0, 1'h1, 6'(a), 0);
		drain("normal reads");
		for (int a = 0; a < 4; a++) burst(1'h1, 1'h1, 6'(a), 2);
		for (int a = 0; a < 4; a++) burst(1'h0, 1'h1, 6'(a), 0);
		drain("concurrent");
		single_mode <= 1'h1;
		repeat (10) @(posedge sys_clk);
		for (int a = 4; a < 12; a++) burst(1'h0, 1'h1, 6'(a), 0);
		repeat (4) @(posedge sys_clk);
		burst(1'h1, 1'h0, 6'h0, 1);
		burst(1'h0, 1'h1, 6'h0, 0);
		drain("single reads");
		tally_and_finish();
	end
endmodule
